// *** rtcs_checker.sv ***
/* checker for the two-wire slave with counter hold.
   bound to rtcs_slave; sees only its ports, one clock domain. */
`timescale 1ns/1ps
module rtcs_checker (
  input wire       clk,
  input wire       resetn,
  input wire       scl_in,
  input wire       sda_in,
  input wire       sda_out,
  input wire       sda_oe,
  input wire       osc_running,
  input wire       tick_2hz,
  input wire       tick_1hz,
  input wire       counter_hold,
  input wire       apply_pending,
  input wire       apply_strobe,
  input wire       wr_valid,
  input wire       wr_ready,
  input wire [3:0] wr_addr,
  input wire [3:0] wr_nibble,
  input wire       wr_high,
  input wire [3:0] rd_addr,
  input wire [7:0] rd_data,
  input wire       busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ******
  // pin history and timebase pulses since the latest start
  // ******
  reg       sp;  // data pin one cycle ago
  reg       cp;  // clock pin one cycle ago
  reg [1:0] tc;  // saturates, so a long hold cannot wrap back to zero
  wire st  = sp && !sda_in && scl_in && cp;
  wire stp = !sp && sda_in && scl_in && cp;
  // counts only while frozen; a start begins the wait anew
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sp <= 1'b1;
      cp <= 1'b1;
      tc <= 2'h0;
    end else begin
      sp <= sda_in;
      cp <= scl_in;
      if (!counter_hold || st)
        tc <= 2'h0;
      else if (tick_2hz && tc != 2'h3)
        tc <= tc + 2'h1;
    end
  end
  // ******
  // assertions
  // ******
  property p_pull_only; sda_oe |-> !sda_out; endproperty
  a_pull_only: assert property (p_pull_only) else $error("data driven high");
  property p_start_hold; st && osc_running |-> ##[1:6] counter_hold; endproperty
  a_start_hold: assert property (p_start_hold) else $error("start did not freeze");
  property p_stop_free; stp |-> ##[1:6] (!sda_oe && !counter_hold); endproperty
  a_stop_free: assert property (p_stop_free) else $error("stop did not release");
  property p_ack_low; $rose(sda_oe) |-> !scl_in && !$past(scl_in); endproperty
  a_ack_low: assert property (p_ack_low) else $error("data pulled under clock high");
  property p_strobe;
    apply_strobe |-> $past(apply_pending || (tick_1hz && counter_hold)) && !counter_hold
      ##1 !apply_strobe;
  endproperty
  a_strobe: assert property (p_strobe) else $error("bad catch-up pulse");
  property p_pending; tick_1hz && counter_hold |=> apply_pending || apply_strobe; endproperty
  a_pending: assert property (p_pending) else $error("missed second lost");
  property p_timeout; tc == 2'h2 |-> ##[1:4] !counter_hold; endproperty
  a_timeout: assert property (p_timeout) else $error("hold outlived timeout");
  property p_osc; $rose(sda_oe) |-> osc_running; endproperty
  a_osc: assert property (p_osc) else $error("answer with oscillator stopped");
  property p_rd_top; $rose(resetn) |-> rd_addr == 4'hf; endproperty
  a_rd_top: assert property (p_rd_top) else $error("read pointer not at top");
  c_nibble: cover property (wr_valid && wr_ready);
  c_strobe: cover property (apply_strobe);
  c_timeout: cover property (tc == 2'h2);
endmodule
bind rtcs_slave rtcs_checker i_chk (.*);

// *** rtcs_defines.vh ***
/*
 * shared constants of the two-wire slave with counter hold.
 * assumes inclusion by bare name; of the design files of this block only the slave includes it.
 */
`ifndef RTCS_DEFINES_VH
`define RTCS_DEFINES_VH

// ****************************************************************
// bus address and framing
// ****************************************************************
`define RTCS_DEV_ADDR     7'h32
`define RTCS_ADDR_BITS    4
`define RTCS_TOP_ADDR     4'hf
`define RTCS_NIBBLE_BITS  4

// ****************************************************************
// timing and fifo size
// ****************************************************************
`define RTCS_CLK_HZ       20000000
`define RTCS_TICK_PULSES  2'h2
`define RTCS_FIFO_DEPTH   16
`define RTCS_FIFO_WIDTH   8

`endif

// *** rtcs_fifo.v ***
/*
 * small synchronous fifo with valid and ready on both sides.
 * assumes one clock and an asynchronous active low reset.
 */
`timescale 1ns/1ps
module rtcs_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             resetn,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output reg              out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);
  // ****************************************************************
  // storage and pointers
  // ****************************************************************
  reg [WIDTH-1:0] mem [0:DEPTH-1];  // word storage
  reg [AW:0]      wr_ptr;           // write pointer, one wrap bit
  reg [AW:0]      rd_ptr;           // read pointer, one wrap bit
  wire            empty;
  wire            full;
  wire            pop;

  assign empty    = (wr_ptr == rd_ptr);
  assign full     = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready = ~full;
  // refill the output register whenever it is free or being taken
  assign pop      = ~empty && (~out_valid || out_ready);

  // write side, memory has no reset
  always @(posedge clk) begin
    if (in_valid && ~full) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // pointers and registered read data
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr    <= {(AW+1){1'b0}};
      rd_ptr    <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data  <= {WIDTH{1'b0}};
    end else begin
      if (in_valid && ~full) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        out_data  <= mem[rd_ptr[AW-1:0]];
        out_valid <= 1'b1;
        rd_ptr    <= rd_ptr + 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule

// *** rtcs_master.sv ***
/* bus master model driving the two-wire slave.
   assumes the bench builds the pulled-up data wire from pull and sda_oe. */
`timescale 1ns/1ps
module rtcs_master (
  output reg  scl_in,
  output reg  pull,
  input  wire sda_in
);
  localparam LO = 280;  // long low phase leaves room for the slave's lag
  localparam HI = 120;  // 400 ns bit period
  integer i;
  reg     r;
  // clock stands high between frames
  initial begin
    scl_in = 1'b1;
    pull = 1'b0;
  end
  // one bit: change under clock low, sample mid high
  task clk_bit(input b, output rb); begin
    #60 pull = !b;
    #(LO - 60) scl_in = 1'b1;
    #(HI / 2) rb = sda_in;
    #(HI / 2) scl_in = 1'b0;
  end endtask
  // frames stay short and never reach the reserved place
  task start; begin
    if (!scl_in) begin // repeated start: lift data, then clock
      #60 pull = 1'b0;
      #(LO - 60) scl_in = 1'b1;
    end
    #300 pull = 1'b1;
    #300 scl_in = 1'b0;
  end endtask
  task stop; begin
    #60 pull = 1'b1;
    #(LO - 60) scl_in = 1'b1;
    #300 pull = 1'b0;
    #62000;
  end endtask
  // n bits msb first; a full byte also clocks the answer bit
  task send(input [7:0] v, input integer n, output ak); begin
    for (i = 0; i < n; i = i + 1) clk_bit(v[7 - i], r);
    if (n == 8) clk_bit(1'b1, r);
    ak = !r;
  end endtask
  task recv(input ak, output [7:0] v); begin
    for (i = 0; i < 8; i = i + 1) clk_bit(1'b1, v[7 - i]);
    clk_bit(!ak, r);
  end endtask
endmodule

// *** rtcs_slave.v ***
/*
 * two-wire slave front end with counter freeze and nibble writes.
 * assumes scl and sda arrive asynchronously, tick_2hz is a clk-domain
 * pulse from the timebase, and rd_data answers rd_addr one cycle later.
 */
`timescale 1ns/1ps
`include "rtcs_defines.vh"
module rtcs_slave (
  input  wire       clk,
  input  wire       resetn,
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe,
  input  wire       osc_running,
  input  wire       tick_2hz,
  input  wire       tick_1hz,
  output reg        counter_hold,
  output reg        apply_pending,
  output reg        apply_strobe,
  output reg        wr_valid,
  input  wire       wr_ready,
  output reg  [3:0] wr_addr,
  output reg  [3:0] wr_nibble,
  output reg        wr_high,
  output reg  [3:0] rd_addr,
  input  wire [7:0] rd_data,
  output reg        busy
);
  // ****************************************************************
  // states, one-hot
  // ****************************************************************
  localparam [5:0] ST_IDLE = 6'h01;  // waiting for start
  localparam [5:0] ST_ADR  = 6'h02;  // shifting address byte
  localparam [5:0] ST_AACK = 6'h04;  // address acknowledge slot
  localparam [5:0] ST_RX   = 6'h08;  // receiving byte
  localparam [5:0] ST_TX   = 6'h10;  // sending byte
  localparam [5:0] ST_MACK = 6'h20;  // master acknowledge slot

  // ****************************************************************
  // line sampling and condition detect
  // ****************************************************************
  wire [1:0] lines;      // {scl, sda} synchronised
  reg        scl_d;      // previous scl
  reg        sda_d;      // previous sda
  wire       scl_rise;
  wire       scl_fall;
  wire       start_det;
  wire       stop_det;

  rtcs_sync #(.W(2), .RST(2'h3)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      ({scl_in, sda_in}),
    .q      (lines)
  );

  // edge history of the synchronised lines
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= lines[1];
      sda_d <= lines[0];
    end
  end

  assign scl_rise  = lines[1] & ~scl_d;
  assign scl_fall  = ~lines[1] & scl_d;
  // data change while clock high is a condition, not data
  assign start_det = lines[1] & scl_d & sda_d & ~lines[0];
  assign stop_det  = lines[1] & scl_d & ~sda_d & lines[0];

  // ****************************************************************
  // protocol state
  // ****************************************************************
  reg [5:0] state;
  reg [2:0] bitcnt;     // bits shifted in the current byte
  reg [7:0] shreg;      // shift register, msb first
  reg       is_read;    // direction of the current transaction
  reg       first_rx;   // next received byte is the pointer
  reg [3:0] ptr;        // register pointer
  reg       ack_drive;  // pulling the acknowledge low
  reg       nack;       // master withheld acknowledge
  reg [1:0] ticks;      // timebase pulses since last start
  reg       ack_ok;     // address matched, oscillator running
  reg       fifo_in_v;  // nibble offered to the fifo
  reg [8:0] fifo_in_d;  // {high half, pointer, nibble}
  wire      fifo_in_rdy;
  wire      fifo_out_v;
  wire [8:0] fifo_out_d;
  wire      timeout;
  reg       got8;       // eighth bit taken, acknowledge slot is next
  wire      drop;       // stop or watchdog ends the frame

  // pointer-free read starts at top address, so reset ptr there
  assign timeout = (ticks == `RTCS_TICK_PULSES);
  // one name for every place that must abandon the frame, so the
  // machine, the data line and the hold all agree on the same cycle,
  // save a start on that cycle, which sets the hold while the machine goes idle,
  // and none of them can lag the others by a clock
  assign drop    = stop_det | timeout;

  // address match, also gated by a running oscillator
  always @* begin
    ack_ok = (shreg[7:1] == `RTCS_DEV_ADDR) && osc_running;
  end

  // nibble buffer between the bus and the register file
  rtcs_fifo #(.WIDTH(9), .DEPTH(`RTCS_FIFO_DEPTH), .AW(4)) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (fifo_in_v),
    .in_ready  (fifo_in_rdy),
    .in_data   (fifo_in_d),
    .out_valid (fifo_out_v),
    .out_ready (wr_ready),
    .out_data  (fifo_out_d)
  );

  // main protocol machine
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state     <= ST_IDLE;
      bitcnt    <= 3'h0;
      shreg     <= 8'h00;
      is_read   <= 1'b0;
      first_rx  <= 1'b0;
      ptr       <= `RTCS_TOP_ADDR;
      ack_drive <= 1'b0;
      nack      <= 1'b0;
      got8      <= 1'b0;
      fifo_in_v <= 1'b0;
      fifo_in_d <= 9'h000;
    end else begin
      fifo_in_v <= 1'b0;
      if (drop) begin
        // stop or watchdog drops everything and lets go of sda
        state     <= ST_IDLE;
        ack_drive <= 1'b0;
        bitcnt    <= 3'h0;
        got8      <= 1'b0;
      end else if (start_det) begin
        // repeated start lands here as well; a half byte left over
        // from the cut frame must never open an acknowledge slot
        state     <= ST_ADR;
        bitcnt    <= 3'h0;
        ack_drive <= 1'b0;
        got8      <= 1'b0;
      end else begin
        case (state)
          ST_ADR: begin
            if (scl_rise) begin
              shreg  <= {shreg[6:0], lines[0]};
              bitcnt <= bitcnt + 3'h1;
              got8   <= (bitcnt == 3'h7);
            end
            // eighth falling edge opens the acknowledge slot. the clock
            // fall that closes the start condition also meets a zero bit
            // count, so the bit count alone cannot tell the two apart
            if (scl_fall && got8) begin
              got8 <= 1'b0;
              if (ack_ok) begin
                ack_drive <= 1'b1;
                is_read   <= shreg[0];
                first_rx  <= ~shreg[0];
                state     <= ST_AACK;
              end else begin
                state <= ST_IDLE;  // other address, stay quiet
              end
            end
          end
          ST_AACK, ST_MACK: begin
            if (scl_fall) begin
              // ninth falling edge ends the slot
              ack_drive <= 1'b0;
              bitcnt    <= 3'h0;
              if (is_read && !(state == ST_MACK && nack)) begin
                shreg <= rd_data;
                ptr   <= ptr + 4'h1;
                state <= ST_TX;
              end else if (is_read) begin
                state <= ST_IDLE;
              end else begin
                state <= ST_RX;
              end
            end
            if (state == ST_MACK && scl_rise) begin
              nack <= lines[0];
            end
          end
          ST_RX: begin
            if (scl_rise) begin
              shreg  <= {shreg[6:0], lines[0]};
              bitcnt <= bitcnt + 3'h1;
              // commit a nibble after bit four and bit eight
              if (!first_rx && bitcnt[1:0] == 2'h3 && fifo_in_rdy) begin
                fifo_in_v <= 1'b1;
                fifo_in_d <= {~bitcnt[2], ptr, shreg[2:0], lines[0]};
              end
            end
            if (scl_fall && bitcnt == 3'h0) begin
              ack_drive <= 1'b1;
              state     <= ST_AACK;
              if (first_rx) begin
                ptr      <= shreg[3:0];
                first_rx <= 1'b0;
              end else begin
                ptr <= ptr + 4'h1;
              end
            end
          end
          ST_TX: begin
            // shift out on falling edges, clock low window
            if (scl_fall) begin
              bitcnt <= bitcnt + 3'h1;
              shreg  <= {shreg[6:0], 1'b1};
              if (bitcnt == 3'h7) begin
                state <= ST_MACK;
                nack  <= 1'b0;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // read pointer follows ptr; the top address wraps naturally
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_addr <= `RTCS_TOP_ADDR;
    end else begin
      rd_addr <= ptr;
    end
  end

  // ****************************************************************
  // open-drain data line
  // ****************************************************************
  // only ever drives low; high means release
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      // the watchdog lets go at once, even with the clock high, since a
      // host that stalled mid-frame may never clock the bit out
      if (drop) begin
        sda_oe <= 1'b0;
      end else if (ack_drive) begin
        sda_oe <= 1'b1;
      end else if (state == ST_TX) begin
        sda_oe <= ~shreg[7];
      end else begin
        sda_oe <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // counter hold and watchdog
  // ****************************************************************
  // watchdog counts timebase pulses while held; start re-arms it.
  // the apply request is a level so a late tick is not lost; only one
  // missed second can be owed, more would need a wider count.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      counter_hold  <= 1'b0;
      ticks         <= 2'h0;
      apply_pending <= 1'b0;
      apply_strobe  <= 1'b0;
      busy          <= 1'b0;
    end else begin
      apply_strobe <= 1'b0;
      busy         <= (state != ST_IDLE);
      // ticks count only while held; any start clears them again, so
      // a host that keeps restarting keeps the counters frozen, which
      // is the price of never updating time under an open frame
      if (start_det) begin
        counter_hold <= 1'b1;
        ticks        <= 2'h0;
      end else if (drop) begin
        counter_hold <= 1'b0;
        ticks        <= 2'h0;
        apply_strobe <= apply_pending | (tick_1hz & counter_hold);
      end else if (counter_hold && tick_2hz) begin
        ticks <= ticks + 2'h1;
      end
      // kept out of the chain above: a second that lands on a restart
      // must still be owed, so only a real end of frame clears it
      if (drop && !start_det) begin
        apply_pending <= 1'b0;
      end else if (counter_hold && tick_1hz) begin
        apply_pending <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // register write port, fed from the fifo
  // ****************************************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_valid  <= 1'b0;
      wr_addr   <= 4'h0;
      wr_nibble <= 4'h0;
      wr_high   <= 1'b0;
    end else begin
      wr_valid  <= fifo_out_v & wr_ready;
      wr_high   <= fifo_out_d[8];
      wr_addr   <= fifo_out_d[7:4];
      wr_nibble <= fifo_out_d[3:0];
    end
  end
endmodule

// *** rtcs_slave_tb.sv ***
/* bench for the two-wire slave: master model, register file, nibble sink.
   assumes the checker binds itself to the slave. */
`timescale 1ns/1ps
module rtcs_slave_tb;
  reg clk, resetn, osc_running, tick_2hz, tick_1hz, wr_ready;
  reg [7:0] rd_data;
  wire scl_in, pull, sda_out, sda_oe, counter_hold, apply_pending;
  wire apply_strobe, wr_valid, wr_high, busy;
  wire [3:0] wr_addr, wr_nibble, rd_addr;
  wire sda_in = (sda_oe ? sda_out : 1'b1) & !pull; // pull-up wins when released
  reg [7:0] regs [0:15]; // register contents
  reg [8:0] nq [$];      // taken nibbles {addr, high, data}
  integer err_total, n_compared, sc, k;
  reg a;
  reg [7:0] d;
  rtcs_slave i_dut (.*);
  rtcs_master i_mst (.scl_in(scl_in), .pull(pull), .sda_in(sda_in));
  // ******
  // clock, register file and sinks
  // ******
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    rd_data <= regs[rd_addr];
    if (wr_valid && wr_ready) nq.push_back({wr_addr, wr_high, wr_nibble});
    if (apply_strobe) sc = sc + 1;
  end
  // ******
  // shared tasks
  // ******
  task chk(input [8:0] g, input [8:0] e); begin
    n_compared = n_compared + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  end endtask
  task tick(input two); begin
    @(posedge clk) if (two) tick_2hz <= 1'b1; else tick_1hz <= 1'b1;
    @(posedge clk) {tick_2hz, tick_1hz} <= 2'h0;
  end endtask
  // ******
  // scenarios
  // ******
  task t_write; begin // pointer f wraps to 0; seconds missed meanwhile
    nq = {};
    sc = 0;
    i_mst.start;
    i_mst.send(8'h64, 8, a);
    chk(a, 1'b1);
    i_mst.send(8'h0f, 8, a);
    i_mst.send(8'ha5, 8, a);
    tick(1'b0);
    tick(1'b0);
    i_mst.send(8'h3c, 8, a);
    chk(a, 1'b1);
    chk(counter_hold, 1'b1);
    chk(apply_pending, 1'b1);
    i_mst.stop;
    chk(sc, 1);
    chk(9'(nq.size()), 4);
    chk(nq[0], 9'h1fa);
    chk(nq[1], 9'h1e5);
    chk(nq[2], 9'h013);
    chk(nq[3], 9'h00c);
    $display("write done");
  end endtask
  task t_read; begin // read across the wrap, then decline
    i_mst.start;
    i_mst.send(8'h64, 8, a);
    i_mst.send(8'h0e, 8, a);
    i_mst.start;
    i_mst.send(8'h65, 8, a);
    chk(a, 1'b1);
    i_mst.recv(1'b1, d);
    chk(d, regs[14]);
    i_mst.recv(1'b1, d);
    chk(d, regs[15]);
    i_mst.recv(1'b0, d);
    chk(d, regs[0]);
    i_mst.stop;
    $display("read done");
  end endtask
  task t_refuse; begin // foreign address, then stopped oscillator
    i_mst.start;
    i_mst.send(8'h66, 8, a);
    chk(a, 1'b0);
    i_mst.stop;
    @(posedge clk) osc_running <= 1'b0;
    i_mst.start;
    i_mst.send(8'h64, 8, a);
    chk(a, 1'b0);
    i_mst.stop;
    @(posedge clk) osc_running <= 1'b1;
    $display("refuse done");
  end endtask
  task t_midstop; begin // stop after six bits keeps one nibble
    nq = {};
    i_mst.start;
    i_mst.send(8'h64, 8, a);
    i_mst.send(8'h05, 8, a);
    i_mst.send(8'hb7, 6, a);
    i_mst.stop;
    chk(9'(nq.size()), 1);
    chk(nq[0], 9'h0bb);
    $display("midstop done");
  end endtask
  task t_timeout; begin // a restart renews the wait
    i_mst.start;
    i_mst.send(8'h64, 8, a);
    tick(1'b1);
    i_mst.start;
    i_mst.send(8'h64, 8, a);
    tick(1'b1);
    chk(counter_hold, 1'b1);
    tick(1'b1);
    repeat (8) @(posedge clk);
    chk(counter_hold, 1'b0);
    chk(busy, 1'b0);
    chk(sda_oe, 1'b0);
    i_mst.stop;
    $display("timeout done");
  end endtask
  task t_fifo; begin // sink stalls: 16 stored plus the output stage, rest dropped
    nq = {};
    @(posedge clk) wr_ready <= 1'b0;
    i_mst.start;
    i_mst.send(8'h64, 8, a);
    i_mst.send(8'h00, 8, a);
    for (k = 0; k < 9; k = k + 1) i_mst.send(8'h12, 8, a);
    i_mst.stop;
    chk(9'(nq.size()), 0);
    @(posedge clk) wr_ready <= 1'b1;
    repeat (40) @(posedge clk);
    chk(9'(nq.size()), 17);
    chk(nq[0], 9'h011);
    chk(nq[15], 9'h0e2);
    chk(nq[16], 9'h111);
    $display("fifo done");
  end endtask
  task t_noptr; begin // fresh reset, read with no pointer set
    @(posedge clk) resetn <= 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    i_mst.start;
    i_mst.send(8'h65, 8, a);
    i_mst.recv(1'b0, d);
    chk(d, regs[15]);
    i_mst.stop;
    $display("noptr done");
  end endtask
  task close_out; begin
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end endtask
  // ******
  // main sequence and watchdog
  // ******
  initial begin
    {err_total, n_compared, sc} = 0;
    {resetn, tick_2hz, tick_1hz} = 3'h0;
    {osc_running, wr_ready} = 2'h3;
    rd_data = 8'h00;
    for (k = 0; k < 16; k = k + 1) regs[k] = {k[3:0], ~k[3:0]};
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    t_write;
    t_read;
    t_refuse;
    t_midstop;
    t_timeout;
    t_fifo;
    t_noptr;
    close_out;
  end
  // about five times the expected run
  initial begin
    #3000000;
    err_total = err_total + 1;
    $display("[ERR] %0t watchdog", $time);
    close_out;
  end
endmodule

// *** rtcs_sync.v ***
/*
 * two flip-flop synchroniser for a group of level inputs.
 * assumes the inputs come from outside the clk domain.
 */
`timescale 1ns/1ps
module rtcs_sync #(
  parameter W = 2,
  parameter RST = 2'h3
) (
  input  wire         clk,
  input  wire         resetn,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  // ****************************************************************
  // synchroniser chain
  // ****************************************************************
  reg [W-1:0] meta;  // first stage, read only by q

  // idle bus lines are high, so reset to released level
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta <= RST;
      q    <= RST;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
